// >>> core/sysref_pkg.sv
// shared types and constants for the sync pulse generator and phase delay block
package sysref_pkg;

    // ==========================================================
    // bus carriers
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    // ==========================================================
    // register offsets
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] COUNT_OFS = 12'h004;
    localparam logic [11:0] RATE_OFS = 12'h008;
    localparam logic [11:0] GDELAY_OFS = 12'h00C;
    localparam logic [11:0] STATUS_OFS = 12'h010;
    localparam logic [11:0] CLK_BASE_OFS = 12'h020;
    localparam logic [11:0] REF_BASE_OFS = 12'h040;
    localparam int MAX_CH = 8;
    localparam int MAX_REF = 8;

    // ==========================================================
    // field positions
    localparam int CTRL_TRIG_BIT = 0;
    localparam int CTRL_REPEAT_BIT = 1;
    localparam int CTRL_IDLE_LEVEL_BIT = 2;
    localparam int CTRL_RELEASE_BIT = 3;
    localparam int CTRL_STOP_BIT = 4;
    localparam int RATE_ALIGN_POS = 8;
    localparam int CLK_DIV_POS = 8;
    localparam int REF_FINE_POS = 4;
    localparam int REF_BIAS_BIT = 8;
    localparam int STATUS_REMAIN_POS = 8;

    // ==========================================================
    // reset values
    localparam logic [7:0] DELAY_RST = 8'h00;
    localparam logic [2:0] COARSE_RST = 3'h0;
    localparam logic [7:0] DIV_RST = 8'h01;
    localparam logic [7:0] COUNT_RST = 8'h01;
    localparam logic [6:0] ALIGN_RST = 7'h01;
    localparam logic [3:0] RATE_RST = 4'h0;
    localparam int SHIFT_LEN = 4;

    // pulse period in timebase cycles for each rate code
    function automatic logic [12:0] rate_len(input logic [3:0] idx);
        case (idx)
            4'h0: rate_len = 13'h0040;
            4'h1: rate_len = 13'h0060;
            4'h2: rate_len = 13'h0080;
            4'h3: rate_len = 13'h00C0;
            4'h4: rate_len = 13'h0100;
            4'h5: rate_len = 13'h0180;
            4'h6: rate_len = 13'h0200;
            4'h7: rate_len = 13'h0300;
            4'h8: rate_len = 13'h0400;
            4'h9: rate_len = 13'h0800;
            4'hA: rate_len = 13'h1000;
            4'hB: rate_len = 13'h1400;
            default: rate_len = 13'h0040;
        endcase
    endfunction

endpackage

// >>> core/sysref_pulse_gen_phase_delay.sv
// sync pulse generator with clock and sync phase delay, apb register slave
//
// Contract
// - clock channel delay 256 steps of one period
// - sync coarse delay, 8 half-period steps
// - global sync delay 256 whole-period steps
// - clock inversion via half-period delay setting
// - all delay settings reset to zero
// - align divider gates pulse release; software sets lcm
// - event starts by command or external edge
// - counted mode emits 1..255 then powers down
// - repeat bit selects counted or continuous
// - pulse rate is timebase over rate divider
// - internal release enables, loads count, starts aligned
// - after event output goes low or bias
// - bias bit with level select holds crosspoint
// - continuous mode ignores pulse count
// - external source arms first, rising edge releases
// - repeat and count are global settings
// - pulses start on coincident clock edges
// - delays identical for internal and external trigger
// - idle low, toggle in event, low after
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps

module sysref_pulse_gen_phase_delay #(
    parameter int NUM_CH = 5,
    parameter int NUM_REF = 4
) (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic CLK_EN,
    input wire sysref_pkg::apb_req_t APB_REQ,
    output sysref_pkg::apb_rsp_t APB_RSP,
    input wire logic EXT_TRIG,
    output logic [NUM_CH-1:0] CLOCK_OUT,
    output logic [NUM_REF-1:0] SYNC_OUT,
    output logic [NUM_REF-1:0] SYNC_PWR,
    output logic [NUM_REF-1:0] SYNC_BIAS,
    output logic [NUM_REF-1:0] SYNC_HALF_STEP,
    output logic [NUM_REF*3-1:0] SYNC_FINE_CODE
);
    import sysref_pkg::*;

    // ==========================================================
    // parameter check
    if (NUM_CH < 1 || NUM_CH > MAX_CH || NUM_REF < 1 || NUM_REF > MAX_REF)
    begin : g_bad_param
        $error("channel or output count out of range");
    end

    // ==========================================================
    // state
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ARMED = 4'b0010,
        ST_DELAY = 4'b0100,
        ST_RUN = 4'b1000
    } fsm_t;

    typedef struct packed {
        logic trig_src;
        logic repeat_sel;
        logic idle_level;
        logic [7:0] count_val;
        logic [7:0] gdelay;
        logic [3:0] rate_idx;
        logic [6:0] align_div;
        logic [NUM_CH-1:0][7:0] ch_delay;
        logic [NUM_CH-1:0][7:0] ch_div;
        logic [NUM_CH-1:0][7:0] ch_wait;
        logic [NUM_CH-1:0][7:0] ch_cnt;
        logic [NUM_CH-1:0] ch_run;
        logic [NUM_CH-1:0] clk_out;
        logic [NUM_REF-1:0][2:0] coarse;
        logic [NUM_REF-1:0][2:0] fine;
        logic [NUM_REF-1:0] idle_bias;
        logic [SHIFT_LEN-1:0] pulse_sh;
        logic [SHIFT_LEN-1:0] act_sh;
        logic [NUM_REF-1:0] sync_out;
        logic [NUM_REF-1:0] sync_pwr;
        logic [NUM_REF-1:0] sync_bias;
        fsm_t state;
        logic [12:0] rate_cnt;
        logic [7:0] remain;
        logic [7:0] gwait;
        logic [6:0] align_cnt;
        logic ext_prev;
        logic [31:0] prdata;
        logic pslverr;
    } regs_t;

    regs_t s_reg;
    regs_t s_next;

    // clock channel high phase: first half of the divided period
    function automatic logic clk_high(input logic [7:0] cnt, input logic [7:0] dv);
        logic [8:0] half;
        half = ({1'b0, dv} + 9'h001) >> 1;
        clk_high = {1'b0, cnt} < half;
    endfunction

    // register index decode: returns 1 when addr hits base + 4*i for i < n
    function automatic logic hit(input logic [11:0] addr, input logic [11:0] base,
                                 input int n, output int idx);
        logic [11:0] d;
        d = addr - base;
        idx = int'(d[11:2]);
        hit = (addr >= base) && (d[1:0] == 2'b00) && (idx < n);
    endfunction

    // ==========================================================
    // bus decode
    logic setup_ph;
    logic wr_acc;
    logic [11:0] addr;
    logic [31:0] wd;
    assign setup_ph = APB_REQ.psel && !APB_REQ.penable;
    assign wr_acc = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite;
    assign addr = APB_REQ.paddr;
    assign wd = APB_REQ.pwdata;

    // ==========================================================
    // next state
    always_comb
    begin
        int ci;
        int ri;
        logic ch_hit;
        logic ref_hit;
        logic clk_sync;
        logic release_cmd;
        logic stop_cmd;
        logic ext_rise;
        logic [12:0] len;
        logic [6:0] adiv;
        logic [31:0] rd;
        logic mapped;
        logic pulse_raw;
        logic [1:0] tap;
        ci = 0;
        ri = 0;
        tap = 2'b00;
        pulse_raw = 1'b0;
        mapped = 1'b0;
        s_next = s_reg;
        ch_hit = hit(addr, CLK_BASE_OFS, NUM_CH, ci);
        ref_hit = hit(addr, REF_BASE_OFS, NUM_REF, ri);
        clk_sync = 1'b0;
        release_cmd = 1'b0;
        stop_cmd = 1'b0;
        len = rate_len(s_reg.rate_idx);
        adiv = (s_reg.align_div == 7'h00) ? 7'h01 : s_reg.align_div;
        ext_rise = EXT_TRIG && !s_reg.ext_prev;
        s_next.ext_prev = EXT_TRIG;

        // register writes take effect in the access phase
        if (wr_acc)
        begin
            if (addr == CTRL_OFS)
            begin
                s_next.trig_src = wd[CTRL_TRIG_BIT];
                s_next.repeat_sel = wd[CTRL_REPEAT_BIT];
                s_next.idle_level = wd[CTRL_IDLE_LEVEL_BIT];
                release_cmd = wd[CTRL_RELEASE_BIT];
                stop_cmd = wd[CTRL_STOP_BIT];
            end
            else if (addr == COUNT_OFS)
                s_next.count_val = wd[7:0];
            else if (addr == RATE_OFS)
            begin
                s_next.rate_idx = wd[3:0];
                s_next.align_div = wd[RATE_ALIGN_POS +: 7];
            end
            else if (addr == GDELAY_OFS)
                s_next.gdelay = wd[7:0];
            else if (ch_hit)
            begin
                s_next.ch_delay[ci] = wd[7:0];
                s_next.ch_div[ci] = wd[CLK_DIV_POS +: 8];
                clk_sync = 1'b1;
            end
            else if (ref_hit)
            begin
                s_next.coarse[ri] = wd[2:0];
                s_next.fine[ri] = wd[REF_FINE_POS +: 3];
                s_next.idle_bias[ri] = wd[REF_BIAS_BIT];
            end
        end

        // clock channels restart together so incident edges line up
        for (int c = 0; c < NUM_CH; c++)
        begin
            if (clk_sync)
            begin
                s_next.ch_wait[c] = s_next.ch_delay[c];
                s_next.ch_run[c] = 1'b0;
                s_next.ch_cnt[c] = 8'h00;
            end
            else if (!s_reg.ch_run[c])
            begin
                if (s_reg.ch_wait[c] == 8'h00)
                    s_next.ch_run[c] = 1'b1;
                else
                    s_next.ch_wait[c] = s_reg.ch_wait[c] - 8'h01;
            end
            else if ({1'b0, s_reg.ch_cnt[c]} + 9'h001 >= {1'b0, s_reg.ch_div[c]})
                s_next.ch_cnt[c] = 8'h00;
            else
                s_next.ch_cnt[c] = s_reg.ch_cnt[c] + 8'h01;
            s_next.clk_out[c] = s_next.ch_run[c] && clk_high(s_next.ch_cnt[c], s_reg.ch_div[c]);
        end

        // release-alignment counter, restarted with the channels
        if (clk_sync || s_reg.align_cnt + 7'h01 >= adiv)
            s_next.align_cnt = 7'h00;
        else
            s_next.align_cnt = s_reg.align_cnt + 7'h01;

        // event sequencer; one path for both trigger sources
        unique case (s_reg.state)
            ST_IDLE:
            begin
                if (release_cmd && !stop_cmd)
                begin
                    s_next.gwait = s_reg.gdelay;
                    if (s_next.trig_src)
                        s_next.state = ST_ARMED;
                    else
                        s_next.state = ST_DELAY;
                end
            end
            ST_ARMED:
            begin
                if (ext_rise)
                    s_next.state = ST_DELAY;
            end
            ST_DELAY:
            begin
                if (s_reg.gwait != 8'h00)
                    s_next.gwait = s_reg.gwait - 8'h01;
                else if (s_reg.align_cnt == 7'h00)
                begin
                    s_next.state = ST_RUN;
                    s_next.rate_cnt = 13'h0000;
                    s_next.remain = (s_reg.count_val == 8'h00) ? 8'h01 : s_reg.count_val;
                end
            end
            ST_RUN:
            begin
                if (s_reg.rate_cnt + 13'h0001 >= len)
                begin
                    s_next.rate_cnt = 13'h0000;
                    if (!s_reg.repeat_sel)
                    begin
                        if (s_reg.remain <= 8'h01)
                            s_next.state = ST_IDLE;
                        else
                            s_next.remain = s_reg.remain - 8'h01;
                    end
                end
                else
                    s_next.rate_cnt = s_reg.rate_cnt + 13'h0001;
            end
        endcase
        if (stop_cmd)
            s_next.state = ST_IDLE;

        // pulse shape and per-output coarse delay taps
        pulse_raw = (s_reg.state == ST_RUN) && (s_reg.rate_cnt < (len >> 1));
        s_next.pulse_sh = {s_reg.pulse_sh[SHIFT_LEN-2:0], pulse_raw};
        s_next.act_sh = {s_reg.act_sh[SHIFT_LEN-2:0], s_reg.state == ST_RUN};
        for (int r = 0; r < NUM_REF; r++)
        begin
            tap = s_reg.coarse[r][2:1];
            s_next.sync_out[r] = s_reg.pulse_sh[tap];
            s_next.sync_pwr[r] = s_reg.act_sh[tap];
            s_next.sync_bias[r] = !s_reg.act_sh[tap] && s_reg.idle_bias[r]
                && s_reg.idle_level;
        end

        // read data captured in the setup phase
        mapped = 1'b1;
        rd = 32'h0000_0000;
        if (addr == CTRL_OFS)
            rd = {27'h000_0000, 1'b0, s_reg.state != ST_IDLE, s_reg.idle_level,
                  s_reg.repeat_sel, s_reg.trig_src};
        else if (addr == COUNT_OFS)
            rd = {24'h00_0000, s_reg.count_val};
        else if (addr == RATE_OFS)
            rd = {17'h0_0000, s_reg.align_div, 4'h0, s_reg.rate_idx};
        else if (addr == GDELAY_OFS)
            rd = {24'h00_0000, s_reg.gdelay};
        else if (addr == STATUS_OFS)
            rd = {16'h0000, s_reg.remain, 4'h0, s_reg.state};
        else if (ch_hit)
            rd = {16'h0000, s_reg.ch_div[ci], s_reg.ch_delay[ci]};
        else if (ref_hit)
            rd = {23'h00_0000, s_reg.idle_bias[ri], 1'b0, s_reg.fine[ri], 1'b0,
                  s_reg.coarse[ri]};
        else
            mapped = 1'b0;
        if (setup_ph)
        begin
            s_next.prdata = rd;
            s_next.pslverr = !mapped;
        end

        // clock enable low freezes everything
        if (!CLK_EN)
            s_next = s_reg;
    end

    // ==========================================================
    // state register
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            s_reg <= '0;
            s_reg.ch_div <= {NUM_CH{DIV_RST}};
            s_reg.count_val <= COUNT_RST;
            s_reg.align_div <= ALIGN_RST;
            s_reg.rate_idx <= RATE_RST;
            s_reg.gdelay <= DELAY_RST;
            s_reg.state <= ST_IDLE;
        end
        else
            s_reg <= s_next;
    end

    // ==========================================================
    // outputs
    assign APB_RSP.pready = 1'b1;
    assign APB_RSP.pslverr = s_reg.pslverr && APB_REQ.psel && APB_REQ.penable;
    assign APB_RSP.prdata = s_reg.prdata;
    assign CLOCK_OUT = s_reg.clk_out;
    assign SYNC_OUT = s_reg.sync_out;
    assign SYNC_PWR = s_reg.sync_pwr;
    assign SYNC_BIAS = s_reg.sync_bias;

    // half-step and fine codes steer the analog delay cells
    always_comb
    begin
        for (int r = 0; r < NUM_REF; r++)
        begin
            SYNC_HALF_STEP[r] = s_reg.coarse[r][0];
            SYNC_FINE_CODE[r*3 +: 3] = s_reg.fine[r];
        end
    end

endmodule // sysref_pulse_gen_phase_delay

// >>> tb/conv_rx_model.sv
// converter-side receiver model that counts and times incoming sync pulses
`timescale 1ns/1ps

module conv_rx_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sync_in,
    output logic [15:0] n_rise,
    output logic [15:0] per_len,
    output logic [15:0] hi_len
);
    logic sync_d;
    logic [15:0] cnt;
    logic [15:0] hcnt;

    // ==========
    // edge count, period and high time as a receiver sees them
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync_d <= 1'b0;
            cnt <= 16'h0000;
            hcnt <= 16'h0000;
            n_rise <= 16'h0000;
            per_len <= 16'h0000;
            hi_len <= 16'h0000;
        end
        else
        begin
            sync_d <= sync_in;
            cnt <= cnt + 16'h0001;
            hcnt <= hcnt + 16'h0001;
            if (sync_in && !sync_d)
            begin
                n_rise <= n_rise + 16'h0001;
                per_len <= cnt; // cycles since previous rise
                cnt <= 16'h0001;
                hcnt <= 16'h0001;
            end
            if (!sync_in && sync_d)
                hi_len <= hcnt;
        end
    end
endmodule // conv_rx_model

// >>> tb/sync_gen_assertions.sv
// port-level checker for the sync pulse generator and phase delay block
`timescale 1ns/1ps

module sync_gen_assertions #(
    parameter int NUM_CH = 5,
    parameter int NUM_REF = 4
) (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic CLK_EN,
    input wire sysref_pkg::apb_req_t APB_REQ,
    input wire sysref_pkg::apb_rsp_t APB_RSP,
    input wire logic EXT_TRIG,
    input wire logic [NUM_CH-1:0] CLOCK_OUT,
    input wire logic [NUM_REF-1:0] SYNC_OUT,
    input wire logic [NUM_REF-1:0] SYNC_PWR,
    input wire logic [NUM_REF-1:0] SYNC_BIAS,
    input wire logic [NUM_REF-1:0] SYNC_HALF_STEP,
    input wire logic [NUM_REF*3-1:0] SYNC_FINE_CODE
);
    import sysref_pkg::*;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);

    // ==========
    // pulse halves last at least 8 cycles
    sequence high_run;
        SYNC_OUT[0] [*8];
    endsequence
    sequence low_run;
        !SYNC_OUT[0] [*8];
    endsequence

    // bus write access flag
    logic wr_acc;
    assign wr_acc = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite;

    // ==========
    // output behaviour
    pwr_gate_a: assert property ((SYNC_OUT & ~SYNC_PWR) == '0)
        else $error("sync pulse on an unpowered output");
    fall_quiet_a: assert property ($fell(SYNC_PWR[0]) |-> !SYNC_OUT[0] && !$past(SYNC_OUT[0]))
        else $error("output powered down mid pulse");
    pulse_high_a: assert property ($rose(SYNC_OUT[0]) |-> high_run)
        else $error("sync high phase too short");
    pulse_low_a: assert property ($fell(SYNC_OUT[0]) |-> low_run)
        else $error("sync low phase too short");
    rise_both_a: assert property ($rose(SYNC_PWR[0]) |-> SYNC_OUT[0])
        else $error("event not opened by a rising pulse");
    bias_quiet_a: assert property (SYNC_BIAS[0] |-> !SYNC_OUT[0])
        else $error("bias while pulsing");
    bias_off_a: assert property ((SYNC_BIAS & SYNC_PWR) == '0)
        else $error("bias on a powered output");
    fine_hold_a: assert property (!wr_acc |=> $stable(SYNC_FINE_CODE))
        else $error("fine code moved without a write");
    half_hold_a: assert property (!wr_acc |=> $stable(SYNC_HALF_STEP))
        else $error("half step moved without a write");
endmodule // sync_gen_assertions

bind sysref_pulse_gen_phase_delay sync_gen_assertions #(
    .NUM_CH(NUM_CH),
    .NUM_REF(NUM_REF)
) chk_i (
    .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .CLK_EN(CLK_EN),
    .APB_REQ(APB_REQ), .APB_RSP(APB_RSP), .EXT_TRIG(EXT_TRIG),
    .CLOCK_OUT(CLOCK_OUT), .SYNC_OUT(SYNC_OUT), .SYNC_PWR(SYNC_PWR),
    .SYNC_BIAS(SYNC_BIAS), .SYNC_HALF_STEP(SYNC_HALF_STEP),
    .SYNC_FINE_CODE(SYNC_FINE_CODE)
);

// >>> tb/tb.sv
// self-checking bench for the sync pulse generator and phase delay block
`timescale 1ns/1ps

module tb;
    import sysref_pkg::*;
    logic clk;
    logic rst_n;
    apb_req_t req;
    apb_rsp_t rsp;
    logic ext_trig;
    logic clk_en;
    logic [4:0] clk_out;
    logic [3:0] s_out;
    logic [3:0] s_pwr;
    logic [3:0] s_bias;
    logic [3:0] s_half;
    logic [11:0] s_fine;
    logic [15:0] n_rise;
    logic [15:0] per_len;
    logic [15:0] hi_len;
    logic [15:0] n0;
    logic [31:0] q;
    logic e;
    int n_mismatch;
    int cmp_count;
    logic [15:0] lens [12] = '{16'h0040, 16'h0060, 16'h0080, 16'h00C0, 16'h0100, 16'h0180,
        16'h0200, 16'h0300, 16'h0400, 16'h0800, 16'h1000, 16'h1400};

    // ==========
    // design and receiver model
    sysref_pulse_gen_phase_delay #(.NUM_CH(5), .NUM_REF(4)) uut (
        .CORE_CLK(clk), .RESET_N(rst_n), .CLK_EN(clk_en), .APB_REQ(req), .APB_RSP(rsp),
        .EXT_TRIG(ext_trig), .CLOCK_OUT(clk_out), .SYNC_OUT(s_out), .SYNC_PWR(s_pwr),
        .SYNC_BIAS(s_bias), .SYNC_HALF_STEP(s_half), .SYNC_FINE_CODE(s_fine)
    );
    conv_rx_model rx (
        .clk(clk), .rst_n(rst_n), .sync_in(s_out[0]),
        .n_rise(n_rise), .per_len(per_len), .hi_len(hi_len)
    );

    // ==========
    // clock and watchdog
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        #1_000_000;
        n_mismatch++;
        close_out();
    end

    // ==========
    // verdict, compare and bus tasks
    task automatic close_out;
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        while (rsp.pready !== 1'b1)
            @(posedge clk);
        q = rsp.prdata;
        e = rsp.pslverr;
        req <= '0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        chk(q, exp);
    endtask
    // one event: release or arm, trigger if external, wait for power up and down
    task automatic event_run(input logic [31:0] ctrl, input logic [15:0] n_exp);
        n0 = n_rise;
        xfer(1'b1, CTRL_OFS, ctrl);
        if (ctrl[CTRL_TRIG_BIT])
        begin
            rd(CTRL_OFS, ctrl & 32'h0000_000F);
            xfer(1'b0, STATUS_OFS, 32'h0000_0000); // read back armed state
            chk(q & 32'h0000_000F, 32'h0000_0002);
            chk(s_pwr, 32'h0000_0000);
            ext_trig <= 1'b1;
            @(posedge clk);
            ext_trig <= 1'b0;
        end
        for (int t = 0; t < 400 && s_pwr[0] !== 1'b1; t++)
            @(posedge clk);
        chk(s_pwr, 32'h0000_000F);
        for (int t = 0; t < 20000 && s_pwr[0] !== 1'b0; t++)
            @(posedge clk);
        chk(n_rise - n0, n_exp);
    endtask

    // ==========
    // main sequence
    initial
    begin
        req = '0;
        ext_trig = 1'b0;
        clk_en = 1'b1;
        rst_n = 1'b0;
        n_mismatch = 0;
        cmp_count = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        // reset values and an unmapped place
        rd(GDELAY_OFS, 32'h0000_0000);
        rd(COUNT_OFS, 32'h0000_0001);
        rd(RATE_OFS, 32'h0000_0100);
        for (int i = 0; i < 5; i++)
            rd(CLK_BASE_OFS + 12'(4 * i), 32'h0000_0100);
        for (int i = 0; i < 4; i++)
            rd(REF_BASE_OFS + 12'(4 * i), 32'h0000_0000);
        xfer(1'b1, 12'h0FC, 32'hFFFF_FFFF);
        chk(e, 32'h0000_0001);
        rd(12'h0FC, 32'h0000_0000);
        chk(s_out | s_pwr, 32'h0000_0000);
        // delay settings at their top codes
        xfer(1'b1, CLK_BASE_OFS, 32'h0000_03FF);
        rd(CLK_BASE_OFS, 32'h0000_03FF);
        xfer(1'b1, REF_BASE_OFS, 32'h0000_0077);
        rd(REF_BASE_OFS, 32'h0000_0077);
        chk(s_half[0], 32'h0000_0001);
        chk(s_fine[2:0], 32'h0000_0007);
        xfer(1'b1, REF_BASE_OFS + 12'h004, 32'h0000_0026);
        @(posedge clk);
        chk(s_half[1], 32'h0000_0000);
        chk(s_fine[5:3], 32'h0000_0002);
        xfer(1'b1, GDELAY_OFS, 32'h0000_00FF);
        rd(GDELAY_OFS, 32'h0000_00FF);
        xfer(1'b1, GDELAY_OFS, 32'h0000_0000);
        xfer(1'b1, REF_BASE_OFS, 32'h0000_0000);
        xfer(1'b1, REF_BASE_OFS + 12'h004, 32'h0000_0000);
        // half-period delay inverts a divide-by-2 channel
        xfer(1'b1, CLK_BASE_OFS, 32'h0000_0201);
        xfer(1'b1, CLK_BASE_OFS + 12'h004, 32'h0000_0200);
        repeat (8) @(posedge clk);
        for (int i = 0; i < 4; i++)
        begin
            chk(clk_out[0] ^ clk_out[1], 32'h0000_0001);
            @(posedge clk);
        end
        // every rate code, 255 pulses at the fastest
        for (int i = 0; i < 12; i++)
        begin
            xfer(1'b1, RATE_OFS, 32'h0000_0200 | 32'(i));
            xfer(1'b1, COUNT_OFS, (i == 0) ? 32'h0000_00FF : 32'h0000_0002);
            event_run(32'h0000_0008, (i == 0) ? 16'h00FF : 16'h0002);
            chk(per_len, lens[i]);
            chk(hi_len, lens[i] >> 1);
        end
        // recommended alignment for divide-by-3 channels at rate 384, then count 0
        xfer(1'b1, CLK_BASE_OFS, 32'h0000_0300);
        xfer(1'b1, REF_BASE_OFS, 32'h0000_0011);
        xfer(1'b1, GDELAY_OFS, 32'h0000_0029);
        xfer(1'b1, RATE_OFS, 32'h0000_0305);
        event_run(32'h0000_0008, 16'h0002);
        chk(per_len, 32'h0000_0180);
        xfer(1'b1, COUNT_OFS, 32'h0000_0000);
        event_run(32'h0000_0008, 16'h0001);
        // count reload on back-to-back events, then bias idle
        xfer(1'b1, RATE_OFS, 32'h0000_0200);
        xfer(1'b1, COUNT_OFS, 32'h0000_0003);
        event_run(32'h0000_0008, 16'h0003);
        event_run(32'h0000_0008, 16'h0003);
        xfer(1'b1, REF_BASE_OFS, 32'h0000_0100);
        event_run(32'h0000_000C, 16'h0003);
        repeat (4) @(posedge clk);
        chk(s_bias[1:0], 32'h0000_0001);
        event_run(32'h0000_0008, 16'h0003);
        repeat (4) @(posedge clk);
        chk(s_bias | s_out, 32'h0000_0000);
        // external trigger: idle edge ignored, armed edge releases
        xfer(1'b1, CTRL_OFS, 32'h0000_0001);
        ext_trig <= 1'b1;
        @(posedge clk);
        ext_trig <= 1'b0;
        repeat (20) @(posedge clk);
        chk(s_pwr, 32'h0000_0000);
        event_run(32'h0000_0009, 16'h0003);
        chk(per_len, 32'h0000_0040);
        // continuous mode runs past the count until stopped
        n0 = n_rise;
        xfer(1'b1, CTRL_OFS, 32'h0000_000A);
        for (int t = 0; t < 1000 && n_rise !== n0 + 16'h0005; t++)
            @(posedge clk);
        chk(n_rise - n0, 32'h0000_0005);
        chk(per_len, 32'h0000_0040);
        // clock enable low freezes the running event
        clk_en <= 1'b0;
        n0 = n_rise;
        repeat (200) @(posedge clk);
        chk(n_rise - n0, 32'h0000_0000);
        chk(s_pwr, 32'h0000_000F);
        clk_en <= 1'b1;
        for (int t = 0; t < 100 && s_out[0] !== 1'b0; t++)
            @(posedge clk);
        xfer(1'b1, CTRL_OFS, 32'h0000_0010);
        repeat (10) @(posedge clk);
        chk(s_pwr | s_out, 32'h0000_0000);
        close_out();
    end
endmodule // tb
